// *** logic/ril_cfg.svh ***
// Constants of the restart interlock and acknowledge logic: times, offsets, fields, resets.
`ifndef RIL_CFG_SVH
`define RIL_CFG_SVH

// ----------------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------------
`define RIL_CLK_KHZ          40'h000003D090
`define RIL_CLK_MHZ          16'h00FA
`define RIL_ACK_MIN_MS       40'h0000000096
`define RIL_ACK_MAX_MS       40'h0000000FA0
`define RIL_SHORT_MS         40'h0000007530
`define RIL_DEBOUNCE_MS      40'h000000000A
`define RIL_SELFTEST_MS      40'h0000000064
`define RIL_PULSE_PERIOD_MS  40'h0000000001
`define RIL_PULSE_LEN_US     16'h0001
`define RIL_PULSE_GUARD_CYC  16'h0008
`define RIL_DETECT_CYC       40'h0000000040

// ----------------------------------------------------------------------
// Register offsets, fields and reset values
// ----------------------------------------------------------------------
`define RIL_OFS_CTRL         12'h000
`define RIL_OFS_STATUS       12'h004
`define RIL_OFS_IRQ_STATUS   12'h008
`define RIL_OFS_IRQ_CLEAR    12'h00C
`define RIL_OFS_IRQ_ENABLE   12'h010
`define RIL_CTRL_INTERLOCK_BIT 0
`define RIL_CTRL_RESET       1'h1
`define RIL_IRQ_ENABLE_RESET 4'h0
`define RIL_RESP_NONE        2'h0
`define RIL_RESP_100MS       2'h1
`define RIL_RESP_50MS        2'h2
`define RIL_AXI_OKAY         2'h0
`define RIL_AXI_SLVERR       2'h2

`endif

// *** logic/ril_pkg.sv ***
// Types shared by the restart interlock and acknowledge logic.
package ril_pkg;

	typedef enum logic [2:0] {
		ST_SELFTEST = 3'b000,
		ST_DRIVE_HI = 3'b001,
		ST_DRIVE_LO = 3'b010,
		ST_LOCKED   = 3'b011,
		ST_ON       = 3'b100,
		ST_FAULT    = 3'b101
	} ril_state_t;

	typedef enum logic [2:0] {
		MODE_NONE    = 3'b000,
		MODE_RED_C2  = 3'b001,
		MODE_STD_C2  = 3'b010,
		MODE_FAST_C2 = 3'b011,
		MODE_RED_C1  = 3'b100,
		MODE_STD_C1  = 3'b101,
		MODE_FAST_C1 = 3'b110
	} ril_mode_t;

	typedef struct packed {
		logic supply_first;
		logic third;
		logic second;
		logic first;
	} ril_ctl_t;

	typedef struct packed {
		logic short_circuit;
		logic ignored;
		logic valid;
	} ril_press_t;

	typedef struct packed {
		logic short_circuit;
		logic ignored;
		logic valid;
		logic locked;
	} ril_irq_t;

endpackage

// *** logic/ril_press_timer.sv ***
// Acknowledge input synchroniser, debouncer and press duration timer.
`timescale 1ns/1ns
`include "ril_cfg.svh"
module ril_press_timer #(
	parameter logic [39:0] DEB_CYC   = 40'h0000000010,
	parameter logic [39:0] MIN_CYC   = 40'h0000000100,
	parameter logic [39:0] MAX_CYC   = 40'h0000001000,
	parameter logic [39:0] SHORT_CYC = 40'h0000008000
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          pin_i,
	input  wire logic          mask,
	input  wire logic          arm,
	output ril_pkg::ril_press_t press
);
	import ril_pkg::*;

	// ----------------------------------------------------------------------
	// Synchroniser and debounce
	// ----------------------------------------------------------------------
	logic [2:0]  sh;
	logic        lvl;
	logic        stable;
	logic [39:0] deb_cnt;
	logic [39:0] dur;
	logic        deb_hit;
	logic        fall;
	logic        dur_ok;
	logic        dur_long;

	// Samples taken while our own test pulse is on the pin are not the button.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh  <= 3'h0;
			lvl <= 1'b0;
		end else begin
			sh <= {sh[1:0], pin_i};
			if (sh[1] == sh[2] && !mask) begin
				lvl <= sh[2];
			end
		end
	end

	assign deb_hit  = (lvl != stable) && (deb_cnt >= DEB_CYC - 40'h1);
	assign fall     = deb_hit && stable;
	assign dur_ok   = (dur >= MIN_CYC) && (dur < MAX_CYC);
	assign dur_long = (dur >= MAX_CYC) && (dur < SHORT_CYC);

	always_ff @(posedge aclk) begin
		if (!aresetn || !arm) begin
			stable  <= 1'b0;
			deb_cnt <= 40'h0;
		end else if (lvl == stable || deb_hit) begin
			stable  <= deb_hit ? lvl : stable;
			deb_cnt <= 40'h0;
		end else begin
			deb_cnt <= deb_cnt + 40'h1;
		end
	end

	// ----------------------------------------------------------------------
	// Press duration
	// ----------------------------------------------------------------------
	// The count saturates at the short circuit threshold so it never wraps.
	always_ff @(posedge aclk) begin
		if (!aresetn || !arm || !stable) begin
			dur <= 40'h0;
		end else if (dur != SHORT_CYC) begin
			dur <= dur + 40'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !arm) begin
			press <= '0;
		end else begin
			press.valid         <= fall && dur_ok;
			press.ignored       <= fall && dur_long;
			press.short_circuit <= stable && (dur == SHORT_CYC - 40'h1);
		end
	end

endmodule

// *** logic/ril_interlock.sv ***
// Start/restart interlock, acknowledge button and mode selection with an AXI4-Lite slave.
//
// Behaviour
// - Pin bridged to second input, first supply positive: standard, 100 ms, channel 1.
// - Pin bridged to first input, first supply positive: fast, under 50 ms, channel 1.
// - Self test completes first; only then the response time is shown.
// - Red locked indicator lit while restart locked and both safety outputs off.
// - Yellow ready indicator lit when field clear and interlock active.
// - Press and release within 0.15 s to 4 s switches outputs on.
// - Press held 4 s up to under 30 s is discarded; interlock stays locked.
// - Press held 30 s is a short to supply; enter fault interlock state.
// - Multifunction pin is clocked; own pulses are not read as the button.
// - Valid press unlocks, or triggers gating restart or override, by lock cause.
// - After a gating error, manual trigger works even with beams interrupted.
// - Gating restart or override needs the gating control input held.
// - Interrupted synchronization beams select override, else gating restart.
// - Multifunction pin selects function, reads the button and outputs a signal.
`timescale 1ns/1ns
`include "ril_cfg.svh"
module ril_interlock #(
	parameter logic [39:0] ACK_MIN_CYC      = `RIL_ACK_MIN_MS * `RIL_CLK_KHZ,
	parameter logic [39:0] ACK_MAX_CYC      = `RIL_ACK_MAX_MS * `RIL_CLK_KHZ,
	parameter logic [39:0] SHORT_CYC        = `RIL_SHORT_MS * `RIL_CLK_KHZ,
	parameter logic [39:0] DEBOUNCE_CYC     = `RIL_DEBOUNCE_MS * `RIL_CLK_KHZ,
	parameter logic [39:0] SELFTEST_CYC     = `RIL_SELFTEST_MS * `RIL_CLK_KHZ,
	parameter logic [39:0] PULSE_PERIOD_CYC = `RIL_PULSE_PERIOD_MS * `RIL_CLK_KHZ
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [11:0]   s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [11:0]   s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          multifunction_io_pin_i,
	output logic               multifunction_io_pin_o,
	output logic               multifunction_io_pin_oe,
	input  wire logic          control_input_first,
	input  wire logic          control_input_second,
	input  wire logic          control_input_third,
	input  wire logic          supply_pin_first,
	input  wire logic          field_clear,
	input  wire logic          sync_beams_interrupted,
	input  wire logic          gating_error,
	output logic               safety_output_one,
	output logic               safety_output_two,
	output logic               locked_indicator,
	output logic               ready_indicator,
	output logic               display_valid,
	output logic [1:0]         display_resp_code,
	output ril_pkg::ril_mode_t op_mode,
	output logic               gating_restart_req,
	output logic               override_req,
	output logic               irq
);
	import ril_pkg::*;

	localparam logic [39:0] PULSE_LEN = 40'(`RIL_PULSE_LEN_US * `RIL_CLK_MHZ);
	localparam logic [39:0] PULSE_MASK = PULSE_LEN + 40'(`RIL_PULSE_GUARD_CYC);

	// ----------------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] pin_lvl;
	ril_ctl_t   ctl;

	assign pin_raw = {supply_pin_first, control_input_third, control_input_second,
		control_input_first};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			logic [2:0] sh;
			logic       lvl;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sh  <= 3'h0;
					lvl <= 1'b0;
				end else begin
					sh <= {sh[1:0], pin_raw[gi]};
					if (sh[1] == sh[2]) begin
						lvl <= sh[2];
					end
				end
			end
			assign pin_lvl[gi] = lvl;
		end
	endgenerate

	assign ctl = ril_ctl_t'(pin_lvl);

	// ----------------------------------------------------------------------
	// Register file decode
	// ----------------------------------------------------------------------
	logic        aw_hold;
	logic        w_hold;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        interlock_en;
	ril_irq_t    irq_status;
	ril_irq_t    irq_enable;
	ril_irq_t    irq_event;
	ril_state_t  state;
	ril_state_t  next_state;
	ril_mode_t   mode;
	ril_mode_t   next_mode;

	logic        wr_fire;
	logic        wr_ctrl;
	logic        wr_clear;
	logic        wr_enable;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_val;
	logic [31:0] status_word;

	assign wr_fire   = aw_hold && w_hold && !s_axi_bvalid;
	assign wr_ctrl   = wr_fire && aw_addr[11:2] == `RIL_OFS_CTRL >> 2;
	assign wr_clear  = wr_fire && aw_addr[11:2] == `RIL_OFS_IRQ_CLEAR >> 2;
	assign wr_enable = wr_fire && aw_addr[11:2] == `RIL_OFS_IRQ_ENABLE >> 2;
	assign wr_hit    = wr_ctrl || wr_clear || wr_enable ||
		aw_addr[11:2] == `RIL_OFS_STATUS >> 2 || aw_addr[11:2] == `RIL_OFS_IRQ_STATUS >> 2;

	assign status_word = {20'h00000, ready_indicator, locked_indicator, safety_output_one,
		display_valid, 1'b0, op_mode, 1'b0, state};
	assign rd_hit = s_axi_araddr[11:2] <= `RIL_OFS_IRQ_ENABLE >> 2;
	assign rd_val =
		(s_axi_araddr[11:2] == `RIL_OFS_CTRL >> 2)       ? {31'h00000000, interlock_en} :
		(s_axi_araddr[11:2] == `RIL_OFS_STATUS >> 2)     ? status_word :
		(s_axi_araddr[11:2] == `RIL_OFS_IRQ_STATUS >> 2) ? {28'h0000000, irq_status} :
		(s_axi_araddr[11:2] == `RIL_OFS_IRQ_ENABLE >> 2) ? {28'h0000000, irq_enable} :
		32'h00000000;

	// ----------------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------------
	// One write and one read are held at a time; ready drops until the answer is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RIL_AXI_OKAY;
			aw_hold       <= 1'b0;
			w_hold        <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RIL_AXI_OKAY : `RIL_AXI_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RIL_AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_val;
			s_axi_rresp   <= rd_hit ? `RIL_AXI_OKAY : `RIL_AXI_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// A status bit set by an event in the same cycle as its clear stays set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interlock_en <= `RIL_CTRL_RESET;
			irq_enable   <= `RIL_IRQ_ENABLE_RESET;
			irq_status   <= '0;
			irq          <= 1'b0;
		end else begin
			if (wr_ctrl && w_strb[0]) begin
				interlock_en <= w_data[`RIL_CTRL_INTERLOCK_BIT];
			end
			if (wr_enable && w_strb[0]) begin
				irq_enable <= ril_irq_t'(w_data[3:0]);
			end
			irq_status <= (irq_status & ~((wr_clear && w_strb[0]) ? w_data[3:0] : 4'h0))
				| irq_event;
			irq <= |(irq_status & irq_enable);
		end
	end

	// ----------------------------------------------------------------------
	// Multifunction pin and acknowledge timing
	// ----------------------------------------------------------------------
	// The test pulse drives low against a pressed button; the driver must be current limited.
	logic [39:0] pulse_cnt;
	logic        pulse_on;
	logic        pulse_mask;
	logic        arm;
	ril_press_t  press;

	assign pulse_on   = (state == ST_LOCKED || state == ST_ON) && pulse_cnt < PULSE_LEN;
	assign pulse_mask = pulse_cnt < PULSE_MASK;
	assign arm        = state == ST_LOCKED || state == ST_ON;

	always_ff @(posedge aclk) begin
		if (!aresetn || pulse_cnt >= PULSE_PERIOD_CYC - 40'h1) begin
			pulse_cnt <= 40'h0;
		end else begin
			pulse_cnt <= pulse_cnt + 40'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			multifunction_io_pin_o  <= 1'b0;
			multifunction_io_pin_oe <= 1'b0;
		end else begin
			multifunction_io_pin_o  <= next_state == ST_DRIVE_HI;
			multifunction_io_pin_oe <= next_state == ST_DRIVE_HI || next_state == ST_DRIVE_LO
				|| pulse_on;
		end
	end

	ril_press_timer #(
		.DEB_CYC   (DEBOUNCE_CYC),
		.MIN_CYC   (ACK_MIN_CYC),
		.MAX_CYC   (ACK_MAX_CYC),
		.SHORT_CYC (SHORT_CYC)
	) u_press (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_i   (multifunction_io_pin_i),
		.mask    (pulse_mask),
		.arm     (arm),
		.press   (press)
	);

	// ----------------------------------------------------------------------
	// Mode detection and interlock state machine
	// ----------------------------------------------------------------------
	logic [39:0] phase_cnt;
	logic [2:0]  det_hi;
	logic [2:0]  bridge;
	logic        phase_done;
	logic        cause_gating;
	logic        gating_ctl;
	logic        manual_ok;
	logic        unlock_ok;

	assign phase_done = (state == ST_SELFTEST) ? phase_cnt >= SELFTEST_CYC - 40'h1 :
		phase_cnt >= `RIL_DETECT_CYC - 40'h1;
	assign bridge     = det_hi & ~{ctl.third, ctl.second, ctl.first};
	assign next_mode  = bridge[1] ? (ctl.supply_first ? MODE_STD_C1 : MODE_STD_C2) :
		bridge[0] ? (ctl.supply_first ? MODE_FAST_C1 : MODE_FAST_C2) :
		bridge[2] ? (ctl.supply_first ? MODE_RED_C1 : MODE_RED_C2) : MODE_NONE;
	assign gating_ctl = (mode == MODE_FAST_C1 || mode == MODE_FAST_C2) ? ctl.second : ctl.first;
	assign manual_ok  = press.valid && cause_gating && gating_ctl;
	assign unlock_ok  = (press.valid && !cause_gating && field_clear) ||
		(!interlock_en && !cause_gating && field_clear);

	// The clear field input is expected to already mask beams that gating bridges.
	always_comb begin
		next_state = state;
		unique case (state)
			ST_SELFTEST: if (phase_done) next_state = ST_DRIVE_HI;
			ST_DRIVE_HI: if (phase_done) next_state = ST_DRIVE_LO;
			ST_DRIVE_LO: if (phase_done) next_state = (next_mode == MODE_NONE) ? ST_FAULT : ST_LOCKED;
			ST_LOCKED: begin
				if (press.short_circuit) next_state = ST_FAULT;
				else if (manual_ok || unlock_ok) next_state = ST_ON;
			end
			ST_ON: begin
				if (press.short_circuit) next_state = ST_FAULT;
				else if (!field_clear || gating_error) next_state = ST_LOCKED;
			end
			ST_FAULT: next_state = ST_FAULT;
			default: next_state = ST_FAULT;
		endcase
	end

	assign irq_event = '{short_circuit: press.short_circuit, ignored: press.ignored,
		valid: press.valid, locked: state == ST_ON && next_state == ST_LOCKED};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state        <= ST_SELFTEST;
			phase_cnt    <= 40'h0;
			det_hi       <= 3'h0;
			mode         <= MODE_NONE;
			cause_gating <= 1'b0;
		end else begin
			state     <= next_state;
			phase_cnt <= (next_state != state) ? 40'h0 : phase_cnt + 40'h1;
			if (state == ST_DRIVE_HI && phase_done) det_hi <= {ctl.third, ctl.second, ctl.first};
			if (state == ST_DRIVE_LO && phase_done) mode <= next_mode;
			if (state == ST_LOCKED && next_state == ST_ON) cause_gating <= 1'b0;
			else if (gating_error) cause_gating <= 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			safety_output_one  <= 1'b0;
			safety_output_two  <= 1'b0;
			locked_indicator   <= 1'b0;
			ready_indicator    <= 1'b0;
			display_valid      <= 1'b0;
			display_resp_code  <= `RIL_RESP_NONE;
			op_mode            <= MODE_NONE;
			gating_restart_req <= 1'b0;
			override_req       <= 1'b0;
		end else begin
			safety_output_one  <= next_state == ST_ON;
			safety_output_two  <= next_state == ST_ON;
			locked_indicator   <= next_state == ST_LOCKED || next_state == ST_FAULT;
			ready_indicator    <= next_state == ST_LOCKED && field_clear && interlock_en;
			display_valid      <= next_state == ST_LOCKED || next_state == ST_ON;
			if (state == ST_DRIVE_LO && phase_done) begin
				op_mode           <= next_mode;
				display_resp_code <= (next_mode == MODE_FAST_C1 || next_mode == MODE_FAST_C2)
					? `RIL_RESP_50MS : `RIL_RESP_100MS;
			end
			gating_restart_req <= state == ST_LOCKED && manual_ok && !sync_beams_interrupted;
			override_req       <= state == ST_LOCKED && manual_ok && sync_beams_interrupted;
		end
	end

endmodule

// *** verif/ril_interlock_asserts.sv ***
// Concurrent checks on the ports of the restart interlock block.
`timescale 1ns/1ns
module ril_interlock_asserts #(
	parameter logic [39:0] SELFTEST_CYC = 40'h0000000014
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
	input wire logic        s_axi_rvalid, s_axi_rready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        safety_output_one, safety_output_two,
	input wire logic        locked_indicator, ready_indicator, display_valid,
	input wire logic        gating_restart_req, override_req
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Cycles since reset release, saturating so a long run cannot wrap it.
	logic [15:0] since;
	always_ff @(posedge aclk) begin
		if (!aresetn) since <= 16'h0000;
		else if (since != 16'hFFFF) since <= since + 16'h0001;
	end
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_addr;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_write_answer: assert property (wr_both |=> !s_axi_awready ##1 s_axi_bvalid)
		else $error("write not answered two cycles after both handshakes");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	chk_read_answer: assert property (rd_addr |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered one cycle after address");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	chk_outputs_paired: assert property (safety_output_one == safety_output_two)
		else $error("safety outputs disagree");
	chk_locked_off: assert property (locked_indicator |-> !safety_output_one)
		else $error("locked indicator lit with outputs on");
	chk_ready_locked: assert property (ready_indicator |-> locked_indicator)
		else $error("ready indicator lit outside the interlock");
	chk_selftest_first: assert property (display_valid |-> {24'h000000, since} > SELFTEST_CYC)
		else $error("response time shown before self test ended");
	chk_req_turns_on: assert property (gating_restart_req || override_req |->
		$rose(safety_output_one))
		else $error("restart or override without switching on");
	chk_req_single: assert property (!(gating_restart_req && override_req))
		else $error("restart and override at once");
endmodule
bind ril_interlock ril_interlock_asserts #(.SELFTEST_CYC(SELFTEST_CYC)) u_chk (.*);

// *** verif/ril_button_model.sv ***
// Far side model: acknowledge button, pin bridge and gating control wiring.
`timescale 1ns/1ns
module ril_button_model (
	input  wire logic       btn,
	input  wire logic       cs,
	input  wire logic [1:0] br,
	input  wire logic       multifunction_io_pin_o,
	input  wire logic       multifunction_io_pin_oe,
	output logic            multifunction_io_pin_i,
	output logic            control_input_first,
	output logic            control_input_second,
	output logic            control_input_third
);
	// One button per receiver; a shared line would let another unit's pulses reset it.
	// The released pin reads low through the input pull-down; the device's drive wins.
	assign multifunction_io_pin_i = multifunction_io_pin_oe ? multifunction_io_pin_o : btn;
	assign control_input_first = (br == 2'h0) ? multifunction_io_pin_i : cs;
	assign control_input_second = (br == 2'h1) ? multifunction_io_pin_i : ((br == 2'h0) ? cs : 1'h0);
	assign control_input_third = (br == 2'h2) ? multifunction_io_pin_i : 1'h0;
endmodule

// *** verif/test_restart_interlock_ack_logic.sv ***
// Self-checking bench of the restart interlock and acknowledge logic.
`timescale 1ns/1ns
module test_restart_interlock_ack_logic;
	import ril_pkg::*;
	logic aclk, aresetn, btn, cs, field_clear, sync_beams_interrupted, gating_error;
	logic supply_pin_first, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic multifunction_io_pin_i, multifunction_io_pin_o, multifunction_io_pin_oe;
	logic control_input_first, control_input_second, control_input_third;
	logic safety_output_one, safety_output_two, locked_indicator, ready_indicator;
	logic display_valid, gating_restart_req, override_req, irq;
	logic [1:0]  br, s_axi_bresp, s_axi_rresp, display_resp_code, rr;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	ril_mode_t   op_mode;
	int          error_cnt, n_compared, cyc, n_gr, n_ov, g0, o0;
	// Short counts keep the run brief: min 40, max 200, short 600, period 2000.
	ril_interlock #(.ACK_MIN_CYC(40'h28), .ACK_MAX_CYC(40'hC8), .SHORT_CYC(40'h258),
		.DEBOUNCE_CYC(40'h4), .SELFTEST_CYC(40'h14), .PULSE_PERIOD_CYC(40'h7D0)) uut (.*);
	ril_button_model partner (.*);
	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end
	// One-cycle request pulses are counted here so no scenario can miss them.
	always @(posedge aclk) begin
		cyc++;
		if (gating_restart_req === 1'h1) n_gr++;
		if (override_req === 1'h1) n_ov++;
		if (cyc == 60000) begin
			error_cnt++;
			finish_test();
		end
	end
	// ----------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a; s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic rd_reg(input logic [11:0] a);
		s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rd = s_axi_rdata; rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask
	// Presses start just after a test pulse, so the whole press fits between two.
	task automatic press(input int n);
		for (int i = 0; i < 2500 && multifunction_io_pin_oe !== 1'h1; i++) @(posedge aclk);
		for (int i = 0; i < 2500 && multifunction_io_pin_oe !== 1'h0; i++) @(posedge aclk);
		tick(12);
		btn <= 1'h1;
		tick(n);
		btn <= 1'h0;
		tick(30);
	endtask
	task automatic startup(input logic [1:0] b, input logic s);
		br <= b; supply_pin_first <= s; aresetn <= 1'h0;
		tick(8);
		aresetn <= 1'h1;
		tick(3);
		chk(display_valid, 1'h0);
		for (int i = 0; i < 400 && locked_indicator !== 1'h1; i++) @(posedge aclk);
		tick(2);
		chk(display_valid, 1'h1);
	endtask
	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task automatic t_modes();
		for (int s = 0; s < 2; s++) for (int b = 0; b < 3; b++) begin
			startup(b[1:0], s[0]);
			chk(op_mode, 3 * s + ((b == 0) ? 3 : 3 - b));
			chk(display_resp_code, (b == 0) ? 2 : 1);
		end
		$display("mode selection done");
	endtask
	task automatic t_regs();
		rd_reg(12'h000); chk(rd, 32'h1); chk(rr, 2'h0);
		rd_reg(12'h010); chk(rd, 32'h0);
		rd_reg(12'h004); chk(rd[6:0], 7'h53);
		rd_reg(12'h014); chk(rr, 2'h2); chk(rd, 32'h0);
		wr(12'h014, 32'h1); chk(rr, 2'h2);
		wr(12'h010, 32'h2); rd_reg(12'h010); chk(rd, 32'h2);
		s_axi_wstrb <= 4'hE; wr(12'h010, 32'h0); s_axi_wstrb <= 4'hF;
		rd_reg(12'h010); chk(rd, 32'h2);
		$display("registers done");
	endtask
	task automatic t_press();
		field_clear <= 1'h1;
		tick(6);
		chk({ready_indicator, locked_indicator, safety_output_one}, 3'h6);
		press(20); chk(safety_output_one, 1'h0);
		press(300); chk(safety_output_one, 1'h0);
		rd_reg(12'h008); chk(rd, 32'h4); chk(irq, 1'h0);
		press(100); chk({safety_output_one, safety_output_two, locked_indicator}, 3'h6);
		rd_reg(12'h008); chk(rd, 32'h6); chk(irq, 1'h1);
		wr(12'h00C, 32'h6); rd_reg(12'h008); chk(rd, 32'h0); chk(irq, 1'h0);
		field_clear <= 1'h0;
		tick(6);
		chk({locked_indicator, safety_output_one}, 2'h2);
		wr(12'h000, 32'h0); field_clear <= 1'h1; tick(6); chk(safety_output_one, 1'h1);
		field_clear <= 1'h0; wr(12'h000, 32'h1);
		$display("acknowledge press done");
	endtask
	task automatic t_gating();
		gating_error <= 1'h1; tick(1); gating_error <= 1'h0;
		g0 = n_gr; o0 = n_ov;
		press(100); chk(n_gr + n_ov, g0 + o0); chk(safety_output_one, 1'h0);
		cs <= 1'h1;
		press(100); chk(n_gr, g0 + 1); chk(n_ov, o0);
		gating_error <= 1'h1; tick(1); gating_error <= 1'h0;
		sync_beams_interrupted <= 1'h1;
		press(100); chk(n_ov, o0 + 1); chk(n_gr, g0 + 1);
		cs <= 1'h0; sync_beams_interrupted <= 1'h0;
		$display("gating restart and override done");
	endtask
	task automatic t_short();
		field_clear <= 1'h1;
		press(700);
		rd_reg(12'h004); chk(rd[2:0], 3'h5);
		chk({safety_output_one, locked_indicator}, 2'h1);
		rd_reg(12'h008); chk(rd[3], 1'h1);
		$display("stuck button done");
	endtask
	initial begin
		aresetn = 1'h0; btn = 1'h0; cs = 1'h0; br = 2'h1; supply_pin_first = 1'h1;
		field_clear = 1'h0; sync_beams_interrupted = 1'h0; gating_error = 1'h0;
		s_axi_awaddr = 12'h000; s_axi_araddr = 12'h000; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'h0; s_axi_wvalid = 1'h0; s_axi_bready = 1'h0;
		s_axi_arvalid = 1'h0; s_axi_rready = 1'h0;
		@(posedge aclk);
		t_modes();
		startup(2'h1, 1'h1);
		t_regs();
		t_press();
		t_gating();
		t_short();
		finish_test();
	end
endmodule
